// ---- logic/lttap_lane_flags.sv ----
// Sticky per-lane ordered-set flags, cleared on state change
module lttap_lane_flags #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic     aclk,
    input wire logic     aresetn,
    // Flag hand-off
    lttap_lane_if.flags  lf
);
    import lttap_pkg::*;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Flags restart per state; a hit in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf.seen <= '0;
        end else begin
            lf.seen <= (lf.clr ? '0 : lf.seen) | lf.hit;
        end
    end

    // After a state change only that cycle's hits remain
    property p_clear_on_change;
        lf.clr |=> lf.seen == $past(lf.hit);
    endproperty
    a_clear_on_change: assert property (p_clear_on_change)
        else $error("lane flags not cleared on state change");

    // A hit is never lost
    property p_hit_sticks;
        (lf.hit != '0) |=> ((lf.seen & $past(lf.hit)) == $past(lf.hit));
    endproperty
    a_hit_sticks: assert property (p_hit_sticks)
        else $error("lane hit dropped");

endmodule

// ---- logic/lttap_lane_if.sv ----
// Per-lane sticky flag hand-off between the top and a flag bank
interface lttap_lane_if #(
    parameter int LANES = 4
);
    logic [LANES-1:0] hit;               // Ordered set received, per lane
    logic             clr;               // Training state changed
    logic [LANES-1:0] seen;              // Sticky flags

    modport core  (output hit, output clr, input seen);
    modport flags (input hit, input clr, output seen);
endinterface

// ---- logic/lttap_pkg.sv ----
// Shared constants for the link training debug tap slice
package lttap_pkg;

    // Slice placement within the wider debug vector
    localparam int LTT_TAP_BASE = 320;   // Vector bit of slice bit 0
    localparam int LTT_SLICE_W  = 48;    // Vector bits 367:320
    localparam int LTT_FIELD_W  = 8;     // Width of each per-lane field
    localparam int LTT_LANES    = 4;     // Lanes served by the core

    // Field positions, relative to slice bit 0
    localparam int F_STATE = 0;          // Vector 324:320
    localparam int F_RXS   = 5;          // Vector 326:325
    localparam int F_TXS   = 7;          // Vector 329:327
    localparam int F_TMO   = 10;         // Vector 330
    localparam int F_EXIT  = 11;         // Vector 331
    localparam int F_ACK   = 12;         // Vector 332
    localparam int F_PKT   = 13;         // Vector 335:333
    localparam int F_DET   = 16;         // Vector 343:336
    localparam int F_PAD   = 24;         // Vector 351:344
    localparam int F_TS1   = 32;         // Vector 359:352
    localparam int F_TS2   = 40;         // Vector 367:360

    // Field widths
    localparam int W_STATE = 5;
    localparam int W_RXS   = 2;
    localparam int W_TXS   = 3;
    localparam int W_PKT   = 3;

    // Training state codes named at the slice
    localparam logic [4:0] ST_DETECT_QUIET = 5'h00;
    localparam logic [4:0] ST_DISABLED     = 5'h10;

    // Receive standby sub-state codes
    localparam logic [1:0] RXS_INACTIVE = 2'h0;
    localparam logic [1:0] RXS_IDLE     = 2'h1;
    localparam logic [1:0] RXS_FTS      = 2'h2;
    localparam logic [1:0] RXS_RECOVERY = 2'h3;

    // Transmit standby sub-state codes
    localparam logic [2:0] TXS_INACTIVE = 3'h0;
    localparam logic [2:0] TXS_ENTRY    = 3'h1;
    localparam logic [2:0] TXS_IDLE     = 3'h2;
    localparam logic [2:0] TXS_FTS      = 3'h3;
    localparam logic [2:0] TXS_EXIT     = 3'h4;

    // Requested physical-layer packet types
    localparam logic [2:0] PKT_ELEC_IDLE = 3'h0;
    localparam logic [2:0] PKT_RX_DETECT = 3'h1;
    localparam logic [2:0] PKT_SET_ONE   = 3'h2;
    localparam logic [2:0] PKT_SET_TWO   = 3'h3;
    localparam logic [2:0] PKT_IDLE_DATA = 3'h4;
    localparam logic [2:0] PKT_FTS       = 3'h5;
    localparam logic [2:0] PKT_IDLE_OS   = 3'h6;
    localparam logic [2:0] PKT_COMPLY    = 3'h7;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_MASK    = 8'h04;
    localparam logic [7:0] REG_TAPS_LO = 8'h08;
    localparam logic [7:0] REG_TAPS_HI = 8'h0C;
    localparam logic [7:0] REG_LANE_EN = 8'h10;

    // Interrupt event bits, same layout in status and mask
    localparam int EV_STATE = 0;         // Training state changed
    localparam int EV_TMO   = 1;         // Timeout flag rose
    localparam int EV_EXIT  = 2;         // Exit-done flag rose
    localparam int EV_ACK   = 3;         // Packet sent
    localparam int EV_W     = 4;

    // Reset values
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST   = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- logic/lttap_top.sv ----
// Link training debug tap slice with AXI4-Lite status registers
// Notes on behaviour
// - Five-bit training state on slice bits 4:0.
// - Receive standby sub-state code on bits 6:5.
// - Transmit standby sub-state code on bits 9:7.
// - Timeout flag for current state, bit 10.
// - Transmit exit conditions complete flag, bit 11.
// - Packet-sent acknowledge, exactly one cycle.
// - Requested packet type on bits 15:13.
// - Per-lane receiver detect, upper bits zero.
// - Per-lane PAD forcing flags, upper bits zero.
// - PAD-forced lanes excluded from initialisation.
// - First training set seen, cleared per state.
// - Second training set seen, cleared per state.
module lttap_top #(
    parameter int LANES  = lttap_pkg::LTT_LANES,
    parameter int ADDR_W = 5
) (
    // Clock and reset
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // Training machine observation
    input  wire logic [lttap_pkg::W_STATE-1:0] train_state,
    input  wire logic [lttap_pkg::W_RXS-1:0]   rx_standby_substate,
    input  wire logic [lttap_pkg::W_TXS-1:0]   tx_standby_substate,
    input  wire logic                           state_timeout,
    input  wire logic                           tx_exit_done,
    input  wire logic                           pkt_sent,
    input  wire logic [lttap_pkg::W_PKT-1:0]   pkt_type,
    // Per-lane observation
    input  wire logic [LANES-1:0]               lane_rx_detect,
    input  wire logic [LANES-1:0]               lane_pad_force,
    input  wire logic [LANES-1:0]               lane_first_set_hit,
    input  wire logic [LANES-1:0]               lane_second_set_hit,
    // Debug slice and lane control
    output logic [lttap_pkg::LTT_SLICE_W-1:0]  debug_taps,
    output logic [LANES-1:0]                    lane_init_en,
    output logic                                irq,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0]              s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready
);
    import lttap_pkg::*;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Lanes must fit their fields; the map needs 5 to 8 address bits
    if (LANES < 1 || LANES > LTT_FIELD_W) begin : g_bad_lanes
        $error("LANES must lie between 1 and the per-lane field width");
    end
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must lie between 5 and 8");
    end

    // Registered observation state
    logic [W_STATE-1:0]     state_r;     // Training state code
    logic [W_RXS-1:0]       rxs_r;       // Receive sub-state
    logic [W_TXS-1:0]       txs_r;       // Transmit sub-state
    logic                   tmo_r;       // Timeout flag
    logic                   exit_r;      // Exit-done flag
    logic                   ack_r;       // Sent acknowledge pulse
    logic                   sent_prev_r; // Last sent level
    logic [W_PKT-1:0]       pkt_r;       // Requested packet type
    logic [LANES-1:0]       det_r;       // Receiver detect per lane
    logic [LANES-1:0]       pad_r;       // PAD forcing per lane
    logic [LANES-1:0]       init_en_r;   // Lanes allowed to initialise
    logic                   state_chg;   // State differs from last
    logic                   ack_nxt;     // Next acknowledge value

    // Interrupt state
    logic [EV_W-1:0]        status_r;    // Sticky events
    logic [EV_W-1:0]        status_nxt;  // Next sticky events
    logic [EV_W-1:0]        mask_r;      // Event enables
    logic [EV_W-1:0]        ev;          // Events this cycle
    logic                   irq_r;       // Interrupt level

    // Bus slave state
    logic                   awready_r;   // Write address slot free
    logic                   wready_r;    // Write data slot free
    logic [ADDR_W-1:0]      awaddr_r;    // Held write address
    logic [31:0]            wdata_r;     // Held write data, strobed
    logic                   bvalid_r;    // Write response pending
    logic [1:0]             bresp_r;     // Write response code
    logic                   arready_r;   // Read slot free
    logic                   rvalid_r;    // Read data pending
    logic [31:0]            rdata_r;     // Read data
    logic [1:0]             rresp_r;     // Read response code
    logic                   wr_fire;     // Both write halves held
    logic [31:0]            rd_word;     // Read mux result

    // Lane flag banks
    lttap_lane_if #(.LANES(LANES)) ts1_if ();
    lttap_lane_if #(.LANES(LANES)) ts2_if ();

    // Widen a lane vector into its field, upper bits held at zero
    function automatic logic [LTT_FIELD_W-1:0] lane_field(
        input logic [LANES-1:0] v
    );
        lane_field            = '0;
        lane_field[LANES-1:0] = v;
    endfunction

    // Word-aligned byte address, zero-extended to the map width
    function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w            = '0;
        w[ADDR_W-1:0] = a;
        w[1:0]       = 2'h0;
        return w;
    endfunction

    // Whether an address names a register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = word_addr(a);
        return (w == REG_STATUS) || (w == REG_MASK) ||
               (w == REG_TAPS_LO) || (w == REG_TAPS_HI) ||
               (w == REG_LANE_EN);
    endfunction

    // Keep only the bytes whose strobe is set
    function automatic logic [31:0] strobed(
        input logic [31:0] d,
        input logic [3:0]  s
    );
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // A new state code starts a fresh set of flags
    assign state_chg = (train_state != state_r);
    // Edge of the sent strobe so a held level gives one pulse only
    assign ack_nxt   = pkt_sent && !sent_prev_r;

    // Training codes and flags, sampled every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_DETECT_QUIET;
            rxs_r   <= RXS_INACTIVE;
            txs_r   <= TXS_INACTIVE;
            tmo_r   <= 1'b0;
            exit_r  <= 1'b0;
            pkt_r   <= PKT_ELEC_IDLE;
        end else begin
            state_r <= train_state;
            rxs_r   <= rx_standby_substate;
            txs_r   <= tx_standby_substate;
            tmo_r   <= state_timeout;
            exit_r  <= tx_exit_done;
            pkt_r   <= pkt_type;
        end
    end

    // Sent acknowledge: one cycle per sent packet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_r       <= 1'b0;
            sent_prev_r <= 1'b0;
        end else begin
            ack_r       <= ack_nxt;
            sent_prev_r <= pkt_sent;
        end
    end

    // Per-lane detect and PAD state; forced lanes sit out training
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_r     <= '0;
            pad_r     <= '0;
            init_en_r <= '0;
        end else begin
            det_r     <= lane_rx_detect;
            pad_r     <= lane_pad_force;
            init_en_r <= ~lane_pad_force;
        end
    end

    // Feed the two flag banks
    assign ts1_if.hit = lane_first_set_hit;
    assign ts1_if.clr = state_chg;
    assign ts2_if.hit = lane_second_set_hit;
    assign ts2_if.clr = state_chg;

    // First training set bank
    lttap_lane_flags #(.LANES(LANES)) u_ts1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lf      (ts1_if)
    );

    // Second training set bank
    lttap_lane_flags #(.LANES(LANES)) u_ts2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lf      (ts2_if)
    );

    // Slice assembly; every bit is a flop, unused lanes read zero
    always_comb begin
        debug_taps                       = '0;
        debug_taps[F_STATE +: W_STATE]   = state_r;
        debug_taps[F_RXS +: W_RXS]       = rxs_r;
        debug_taps[F_TXS +: W_TXS]       = txs_r;
        debug_taps[F_TMO]                = tmo_r;
        debug_taps[F_EXIT]               = exit_r;
        debug_taps[F_ACK]                = ack_r;
        debug_taps[F_PKT +: W_PKT]       = pkt_r;
        debug_taps[F_DET +: LTT_FIELD_W] = lane_field(det_r);
        debug_taps[F_PAD +: LTT_FIELD_W] = lane_field(pad_r);
        debug_taps[F_TS1 +: LTT_FIELD_W] = lane_field(ts1_if.seen);
        debug_taps[F_TS2 +: LTT_FIELD_W] = lane_field(ts2_if.seen);
    end
    assign lane_init_en = init_en_r;

    // Events: rising flags, state changes and sent packets
    always_comb begin
        ev           = '0;
        ev[EV_STATE] = state_chg;
        ev[EV_TMO]   = state_timeout && !tmo_r;
        ev[EV_EXIT]  = tx_exit_done && !exit_r;
        ev[EV_ACK]   = ack_nxt;
    end

    // Write one to clear; an event in the same cycle wins
    always_comb begin
        status_nxt = status_r;
        if (wr_fire && word_addr(awaddr_r) == REG_STATUS) begin
            status_nxt = status_nxt & ~wdata_r[EV_W-1:0];
        end
        status_nxt = status_nxt | ev;
    end

    // Sticky status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Mask; strobes already applied to the held data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= MASK_RST;
        end else if (wr_fire && word_addr(awaddr_r) == REG_MASK) begin
            mask_r <= wdata_r[EV_W-1:0];
        end
    end

    // Interrupt level lags the status by one cycle to stay registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end
    assign irq = irq_r;

    // Write fires once both halves are held and no response waits
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;

    // Write address slot, reopens after the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            awaddr_r  <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    // Write data slot, taken in either order with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            wdata_r  <= '0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r  <= strobed(s_axi_wdata, s_axi_wstrb);
        end else if (s_axi_bvalid && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // Read mux; taps and lane enables read live state
    always_comb begin
        rd_word = '0;
        unique case (word_addr(s_axi_araddr))
            REG_STATUS:  rd_word[EV_W-1:0]  = status_r;
            REG_MASK:    rd_word[EV_W-1:0]  = mask_r;
            REG_TAPS_LO: rd_word            = debug_taps[31:0];
            REG_TAPS_HI: rd_word[15:0]      = debug_taps[LTT_SLICE_W-1:32];
            REG_LANE_EN: rd_word[LANES-1:0] = init_en_r;
            default:     rd_word            = '0;
        endcase
    end

    // Read channel, answers in the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // State field tracks the input one cycle later
    property p_state_tap;
        ##1 debug_taps[F_STATE +: W_STATE] == $past(train_state);
    endproperty
    a_state_tap: assert property (p_state_tap)
        else $error("state tap does not follow training state");

    // Receive sub-state field
    property p_rxs_tap;
        ##1 debug_taps[F_RXS +: W_RXS] == $past(rx_standby_substate);
    endproperty
    a_rxs_tap: assert property (p_rxs_tap)
        else $error("receive sub-state tap wrong");

    // Transmit sub-state field
    property p_txs_tap;
        ##1 debug_taps[F_TXS +: W_TXS] == $past(tx_standby_substate);
    endproperty
    a_txs_tap: assert property (p_txs_tap)
        else $error("transmit sub-state tap wrong");

    // Timeout and exit flags follow their sources
    property p_flag_taps;
        ##1 {debug_taps[F_TMO], debug_taps[F_EXIT]} ==
            {$past(state_timeout), $past(tx_exit_done)};
    endproperty
    a_flag_taps: assert property (p_flag_taps)
        else $error("timeout or exit flag tap wrong");

    // Acknowledge is a single-cycle pulse after a sent edge
    property p_ack_pulse;
        $rose(pkt_sent) |=> debug_taps[F_ACK] ##1 !debug_taps[F_ACK];
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("sent acknowledge not one cycle");

    // Packet type field
    property p_pkt_tap;
        ##1 debug_taps[F_PKT +: W_PKT] == $past(pkt_type);
    endproperty
    a_pkt_tap: assert property (p_pkt_tap)
        else $error("packet type tap wrong");

    // Detect and PAD fields: lanes follow, upper bits stay zero
    property p_lane_taps;
        ##1 (debug_taps[F_DET +: LTT_FIELD_W] == lane_field($past(lane_rx_detect)))
            && (debug_taps[F_PAD +: LTT_FIELD_W] == lane_field($past(lane_pad_force)));
    endproperty
    a_lane_taps: assert property (p_lane_taps)
        else $error("detect or PAD tap wrong");

    // A PAD-forced lane is never enabled for initialisation
    property p_pad_excludes;
        (debug_taps[F_PAD +: LANES] & lane_init_en) == '0;
    endproperty
    a_pad_excludes: assert property (p_pad_excludes)
        else $error("PAD-forced lane enabled");

    // Second-set flags restart on a state change
    property p_ts2_clear;
        state_chg |=> debug_taps[F_TS2 +: LTT_FIELD_W] ==
                      lane_field($past(lane_second_set_hit));
    endproperty
    a_ts2_clear: assert property (p_ts2_clear)
        else $error("second-set flags not cleared on state change");

endmodule

// ---- test/lttap_obs.sv ----
// Far-side debug observer that tallies packet-sent pulses
module lttap_obs (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Observed slice
    input  wire logic [47:0] debug_taps,
    // Pulse tally
    output int               acks
);
    import lttap_pkg::*;
    // Counts high cycles, so a stretched pulse shows up as extra
    always @(posedge aclk) begin
        if (!aresetn) acks <= 0;
        else acks <= acks + int'(debug_taps[F_ACK]);
    end
endmodule

// ---- test/test_link_training_debug_taps.sv ----
// Bench with a cycle model of the tap slice and its registers
module test_link_training_debug_taps;
    timeunit 1ns;
    timeprecision 1ps;
    import lttap_pkg::*;
    logic aclk, aresetn, state_timeout, tx_exit_done, pkt_sent, irq, c, ack;
    logic [4:0] train_state, s_axi_awaddr, s_axi_araddr, m_st;
    logic [1:0] rx_standby_substate, s_axi_bresp, s_axi_rresp;
    logic [2:0] tx_standby_substate, pkt_type;
    logic [3:0] lane_rx_detect, lane_pad_force, lane_first_set_hit, lane_second_set_hit;
    logic [3:0] lane_init_en, s_axi_wstrb, s1, s2, m_stat, m_le;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [47:0] debug_taps, exp_taps;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic m_ps, m_pt, m_pe;
    int bad_count, n_compared, seed = 11, acks, acks_exp;
    lttap_top u_dut (.aclk, .aresetn, .train_state, .rx_standby_substate,
        .tx_standby_substate, .state_timeout, .tx_exit_done, .pkt_sent, .pkt_type,
        .lane_rx_detect, .lane_pad_force, .lane_first_set_hit, .lane_second_set_hit,
        .debug_taps, .lane_init_en, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lttap_obs u_obs (.aclk, .aresetn, .debug_taps, .acks);
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Write one word; waits are bounded, a hang ends the run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a[4:0], d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 99) begin bad_count++; results; end
        else chk(48'(s_axi_bresp), 48'(r));
        if (a == REG_STATUS && r == RESP_OKAY) m_stat &= ~d[3:0];
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a[4:0], 2'h3};
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 99) begin bad_count++; results; end
        else chk({s_axi_rresp, s_axi_rdata}, {r, e});
    endtask
    // Slice model: fields one edge late, seen flags restart on a state change
    always @(posedge aclk) begin
        if (!aresetn) {m_st, m_ps, m_pt, m_pe, s1, s2, m_stat, m_le, exp_taps} = '0;
        else begin
            c = train_state != m_st;
            ack = pkt_sent & ~m_ps;
            s1 = c ? lane_first_set_hit : s1 | lane_first_set_hit;
            s2 = c ? lane_second_set_hit : s2 | lane_second_set_hit;
            m_stat |= {ack, tx_exit_done & ~m_pe, state_timeout & ~m_pt, c};
            exp_taps = {4'h0, s2, 4'h0, s1, 4'h0, lane_pad_force, 4'h0, lane_rx_detect,
                pkt_type, ack, tx_exit_done, state_timeout, tx_standby_substate,
                rx_standby_substate, train_state};
            m_le = ~lane_pad_force;
            acks_exp += int'(ack);
            {m_st, m_ps, m_pt, m_pe} = {train_state, pkt_sent, state_timeout, tx_exit_done};
        end
    end
    always @(negedge aclk) if (aresetn) begin
        chk(48'(debug_taps[9:0]), 48'(exp_taps[9:0]));
        chk(48'(debug_taps[15:10]), 48'(exp_taps[15:10]));
        chk(48'(debug_taps[31:16]), 48'(exp_taps[31:16]));
        chk(48'(debug_taps[47:32]), 48'(exp_taps[47:32]));
        chk(48'(lane_init_en), 48'(m_le));
    end
    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, train_state, state_timeout, tx_exit_done, pkt_sent, pkt_type} = '0;
        {rx_standby_substate, tx_standby_substate, s_axi_awaddr, s_axi_araddr} = '0;
        {lane_rx_detect, lane_pad_force, lane_first_set_hit, lane_second_set_hit} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hF};
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        // Random traffic; state changes in about one cycle of four
        repeat (400) @(posedge aclk) begin
            if ($random(seed) % 4 == 0) train_state <= 5'($random(seed));
            {state_timeout, tx_exit_done, pkt_sent, pkt_type, rx_standby_substate,
                tx_standby_substate} <= 11'($random(seed));
            {lane_rx_detect, lane_pad_force, lane_first_set_hit,
                lane_second_set_hit} <= 16'($random(seed));
        end
        // Let the last random values raise their events before the model is read
        repeat (3) @(posedge aclk);
        rd(REG_STATUS, 32'(m_stat), RESP_OKAY);
        wr(REG_MASK, 32'h8, RESP_OKAY);
        rd(REG_MASK, 32'h8, RESP_OKAY);
        chk(48'(irq), 48'(m_stat[3]));
        wr(REG_STATUS, 32'hF, RESP_OKAY);
        rd(REG_STATUS, 32'h0, RESP_OKAY);
        chk(48'(irq), 48'h0);
        // Byte 0 not strobed, so the mask bits are written as zero
        s_axi_wstrb <= 4'hE;
        wr(REG_MASK, 32'hF, RESP_OKAY);
        rd(REG_MASK, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(8'h1C, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'hF, RESP_SLVERR);
        chk(48'(acks), 48'(acks_exp));
        results;
    end
endmodule
